/* flash_cmd.sv */
// serial flash command logic: status/config reads, status write, array read
// assumes: host drives spi mode 0 or 3 far below clk_i; mem_data_i follows mem_addr_o
// within a few cycles; program/erase cycles elsewhere report on ext_busy_i
//
// Overview of operation
// - config status read opcode works even while busy
// - config byte repeats while chip select low
// - config bits 3:2 give output drive strength
// - config bits 5:4 select dummy byte count
// - quad dummy clocks are twice dummy bytes
// - config bits 7,6,1,0 reserved; all volatile
// - status write needs write enable latch set
// - select must rise right after eighth bit
// - valid status write starts timed busy cycle
// - write enable latch clears when cycle ends
// - status read leaves latch and busy alone
// - permanent bit freezes protect, lock, itself
// - otp mode sets lock bits once only while volatile_sr_i is low
// - permanent bit refuses later sector lock
// - read takes opcode, 24-bit address, outputs data
// - address increments per byte, wraps to zero
// - select high stops data drive at once
// - read during busy cycle is ignored
// - latch clear rejects status write commands
// - status bit zero shows busy cycle
`timescale 1ns/100ps

module flash_cmd #(
    parameter int unsigned TW_CYCLES = flash_cmd_pkg::TW_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // spi pins
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // array read port
    output logic [23:0] mem_addr_o,
    input wire logic [7:0] mem_data_i,
    // surrounding device logic
    input wire logic ext_busy_i,
    input wire logic otp_mode_i,
    input wire logic volatile_sr_i,
    input wire logic tuning_we_i,
    input wire logic [7:0] tuning_wdata_i,
    // status outputs
    output logic cycle_busy_flag_o,
    output logic write_enable_latch_o,
    output logic permanent_lock_bit_o,
    output logic [3:0] protect_field_o,
    output logic [1:0] drive_strength_o,
    output logic [2:0] dummy_bytes_o,
    output logic [3:0] quad_dummy_clocks_o
);
    typedef struct packed {
        flash_cmd_pkg::state_e state;
        logic [4:0] bitcnt;
        logic [7:0] cmd;
        logic [23:0] shreg;
        logic [23:0] addr;
        logic [7:0] oshift;
        logic miso;
        logic wsr_busy;
        logic [23:0] tw_cnt;
        logic [7:0] wdata;
        logic wr_otp;
        logic wr_vol;
        logic write_enable_latch;
        logic permanent_lock_bit;
        logic ebl;
        logic [3:0] bp;
        logic otp_lock;
        logic tb;
        logic sect;
        logic [7:0] cfg;
    } core_s;

    core_s r_reg;
    core_s r_next;
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    sync_edge #(.WIDTH(3), .RST_VAL(3'h1)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({mosi_i, sclk_i, cs_n_i}),
        .level_o(pin_level),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    logic cs_high;
    logic sclk_rise;
    logic sclk_fall;
    logic mosi;
    logic busy;
    logic [7:0] opcode;
    logic [7:0] status_byte;
    logic [7:0] cfg_byte;
    logic [7:0] src_byte;
    logic [2:0] bit_idx;
    logic wsr_done;
    logic wsr_valid;

    assign cs_high = pin_level[0];
    assign sclk_rise = pin_rise[1];
    assign sclk_fall = pin_fall[1];
    assign mosi = pin_level[2];
    assign busy = r_reg.wsr_busy | ext_busy_i;
    assign opcode = {r_reg.shreg[6:0], mosi};
    assign bit_idx = r_reg.bitcnt[2:0];
    assign cfg_byte = r_reg.cfg & flash_cmd_pkg::CFG_MASK;
    assign wsr_done = r_reg.wsr_busy && (r_reg.tw_cnt == 24'(TW_CYCLES - 1));
    // exactly eight data bits, latch set and nothing running
    assign wsr_valid = (r_reg.state == flash_cmd_pkg::ST_WDATA) && cs_high
        && (r_reg.bitcnt == flash_cmd_pkg::DATA_BITS) && r_reg.write_enable_latch && !busy;
    // status byte layout follows the otp mode selection
    always_comb begin
        status_byte = 8'h00;
        status_byte[flash_cmd_pkg::SR_BUSY] = busy;
        status_byte[flash_cmd_pkg::SR_WEL] = r_reg.write_enable_latch;
        if (otp_mode_i) begin
            status_byte[flash_cmd_pkg::SR_TOP] = r_reg.otp_lock;
            status_byte[flash_cmd_pkg::SR_SECT] = r_reg.sect;
            status_byte[flash_cmd_pkg::SR_TB] = r_reg.tb;
        end else begin
            status_byte[flash_cmd_pkg::SR_TOP] = r_reg.permanent_lock_bit;
            status_byte[flash_cmd_pkg::SR_EBL] = r_reg.ebl;
            status_byte[flash_cmd_pkg::SR_BP_HI:flash_cmd_pkg::SR_BP_LO] = r_reg.bp;
        end
    end

    always_comb begin
        unique case (r_reg.cmd)
            flash_cmd_pkg::OP_READ: src_byte = mem_data_i;
            flash_cmd_pkg::OP_READ_CONFIG: src_byte = cfg_byte;
            default: src_byte = status_byte;
        endcase
    end

    always_comb begin
        r_next = r_reg;
        // self-timed status write; data lands when the cycle ends
        if (r_reg.wsr_busy) begin
            r_next.tw_cnt = r_reg.tw_cnt + 24'h000001;
        end
        if (wsr_done) begin
            r_next.wsr_busy = 1'b0;
            r_next.write_enable_latch = 1'b0;
            if (r_reg.wr_otp) begin
                if (r_reg.wr_vol) begin
                    r_next.tb = r_reg.wdata[flash_cmd_pkg::SR_TB];
                    r_next.sect = r_reg.wdata[flash_cmd_pkg::SR_SECT];
                end else begin
                    // one-shot bits: a write can only set them
                    r_next.tb = r_reg.tb | r_reg.wdata[flash_cmd_pkg::SR_TB];
                    r_next.sect = r_reg.sect | r_reg.wdata[flash_cmd_pkg::SR_SECT];
                end
                if (r_reg.wdata[flash_cmd_pkg::SR_TOP] && !r_reg.permanent_lock_bit) begin
                    r_next.otp_lock = 1'b1;
                end
            end else begin
                r_next.ebl = r_reg.wdata[flash_cmd_pkg::SR_EBL];
                if (!r_reg.permanent_lock_bit) begin
                    r_next.bp = r_reg.wdata[flash_cmd_pkg::SR_BP_HI:flash_cmd_pkg::SR_BP_LO];
                    r_next.permanent_lock_bit = r_reg.wdata[flash_cmd_pkg::SR_TOP];
                end
            end
        end
        if (tuning_we_i) begin
            r_next.cfg = tuning_wdata_i & flash_cmd_pkg::CFG_MASK;
        end
        if (cs_high) begin
            // frame end: only now does write enable take effect and a status write start its timed cycle
            if ((r_reg.state == flash_cmd_pkg::ST_HOLD)
                && (r_reg.cmd == flash_cmd_pkg::OP_WRITE_ENABLE)
                && (r_reg.bitcnt == flash_cmd_pkg::CMD_BITS) && !busy) begin
                r_next.write_enable_latch = 1'b1;
            end
            if (wsr_valid) begin
                r_next.wsr_busy = 1'b1;
                r_next.tw_cnt = 24'h000000;
                r_next.wr_otp = otp_mode_i;
                r_next.wr_vol = volatile_sr_i;
            end
            r_next.state = flash_cmd_pkg::ST_IDLE;
            r_next.miso = 1'b0;
        end else begin
            unique case (r_reg.state)
                flash_cmd_pkg::ST_IDLE: begin
                    r_next.state = flash_cmd_pkg::ST_CMD;
                    r_next.bitcnt = 5'h00;
                end
                flash_cmd_pkg::ST_CMD: begin
                    if (sclk_rise) begin
                        r_next.shreg = {r_reg.shreg[22:0], mosi};
                        r_next.bitcnt = r_reg.bitcnt + 5'h01;
                        if (r_reg.bitcnt == flash_cmd_pkg::CMD_BITS - 5'h01) begin
                            r_next.cmd = opcode;
                            r_next.bitcnt = 5'h00;
                            unique case (opcode)
                                flash_cmd_pkg::OP_READ: begin
                                    // a running cycle keeps going; the read dies here
                                    r_next.state = busy ? flash_cmd_pkg::ST_HOLD
                                        : flash_cmd_pkg::ST_ADDR;
                                end
                                flash_cmd_pkg::OP_READ_STATUS: begin
                                    r_next.state = flash_cmd_pkg::ST_OUT;
                                end
                                flash_cmd_pkg::OP_READ_CONFIG: begin
                                    r_next.state = flash_cmd_pkg::ST_OUT;
                                end
                                flash_cmd_pkg::OP_WRITE_STATUS: begin
                                    r_next.state = flash_cmd_pkg::ST_WDATA;
                                end
                                flash_cmd_pkg::OP_WRITE_ENABLE: begin
                                    r_next.state = flash_cmd_pkg::ST_HOLD;
                                    r_next.bitcnt = flash_cmd_pkg::CMD_BITS;
                                end
                                default: begin
                                    r_next.state = flash_cmd_pkg::ST_HOLD;
                                end
                            endcase
                        end
                    end
                end
                flash_cmd_pkg::ST_ADDR: begin
                    if (sclk_rise) begin
                        r_next.shreg = {r_reg.shreg[22:0], mosi};
                        r_next.bitcnt = r_reg.bitcnt + 5'h01;
                        if (r_reg.bitcnt == flash_cmd_pkg::ADDR_LAST) begin
                            r_next.addr = {r_reg.shreg[22:0], mosi};
                            r_next.bitcnt = 5'h00;
                            r_next.state = flash_cmd_pkg::ST_OUT;
                        end
                    end
                end
                flash_cmd_pkg::ST_WDATA: begin
                    if (sclk_rise) begin
                        if (r_reg.bitcnt < flash_cmd_pkg::DATA_BITS) begin
                            r_next.wdata = {r_reg.wdata[6:0], mosi};
                            r_next.bitcnt = r_reg.bitcnt + 5'h01;
                        end else begin
                            r_next.bitcnt = flash_cmd_pkg::DATA_OVER;
                        end
                    end
                end
                flash_cmd_pkg::ST_OUT: begin
                    if (sclk_fall) begin
                        if (bit_idx == 3'h0) begin
                            r_next.miso = src_byte[7];
                            r_next.oshift = {src_byte[6:0], 1'b0};
                        end else begin
                            r_next.miso = r_reg.oshift[7];
                            r_next.oshift = {r_reg.oshift[6:0], 1'b0};
                        end
                        if ((bit_idx == 3'h7) && (r_reg.cmd == flash_cmd_pkg::OP_READ)) begin
                            r_next.addr = r_reg.addr + 24'h000001;
                        end
                        r_next.bitcnt = {2'h0, bit_idx + 3'h1};
                    end
                end
                flash_cmd_pkg::ST_HOLD: begin
                    // trailing clocks spoil a write enable frame
                    if (sclk_rise) begin
                        r_next.bitcnt = 5'h00;
                    end
                end
                default: begin
                    r_next.state = flash_cmd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.state <= flash_cmd_pkg::ST_IDLE;
            r_reg.cfg <= flash_cmd_pkg::CFG_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign miso_o = r_reg.miso;
    // gated by the synchronised select level so a high select cuts the drive in the same cycle
    assign miso_oe_o = (r_reg.state == flash_cmd_pkg::ST_OUT) && !cs_high;
    assign mem_addr_o = r_reg.addr;
    assign cycle_busy_flag_o = busy;
    assign write_enable_latch_o = r_reg.write_enable_latch;
    assign permanent_lock_bit_o = r_reg.permanent_lock_bit;
    assign protect_field_o = r_reg.bp;
    assign drive_strength_o = r_reg.cfg[flash_cmd_pkg::CFG_DRV_HI:flash_cmd_pkg::CFG_DRV_LO];
    assign dummy_bytes_o = flash_cmd_pkg::dummy_bytes(
        r_reg.cfg[flash_cmd_pkg::CFG_DUMMY_HI:flash_cmd_pkg::CFG_DUMMY_LO]);
    assign quad_dummy_clocks_o = {dummy_bytes_o, 1'b0};

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_busy_start;
        wsr_valid |=> r_reg.wsr_busy ##1 r_reg.wsr_busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("status write did not go busy");
    property p_wel_clear;
        wsr_done |=> !r_reg.write_enable_latch && !r_reg.wsr_busy;
    endproperty
    a_wel_clear: assert property (p_wel_clear) else $error("latch not cleared at cycle end");
    property p_reject_nowel;
        (r_reg.state == flash_cmd_pkg::ST_WDATA) && cs_high && !r_reg.write_enable_latch && !r_reg.wsr_busy
            |=> !r_reg.wsr_busy;
    endproperty
    a_reject_nowel: assert property (p_reject_nowel) else $error("write ran without latch");
    property p_reject_len;
        (r_reg.state == flash_cmd_pkg::ST_WDATA) && cs_high && !r_reg.wsr_busy
            && (r_reg.bitcnt != flash_cmd_pkg::DATA_BITS) |=> !r_reg.wsr_busy;
    endproperty
    a_reject_len: assert property (p_reject_len) else $error("bad length write ran");
    property p_oe_off;
        cs_high |-> !miso_oe_o ##1 (r_reg.state == flash_cmd_pkg::ST_IDLE) && !r_reg.miso;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven with select high");
    property p_read_ignored;
        (r_reg.state == flash_cmd_pkg::ST_CMD) && sclk_rise && !cs_high
            && (r_reg.bitcnt == 5'h07) && (opcode == flash_cmd_pkg::OP_READ) && busy
            |=> (r_reg.state == flash_cmd_pkg::ST_HOLD)
            && (!r_reg.wsr_busy || (r_reg.tw_cnt != $past(r_reg.tw_cnt)));
    endproperty
    a_read_ignored: assert property (p_read_ignored) else $error("read accepted while busy");
    property p_wrap;
        (r_reg.state == flash_cmd_pkg::ST_OUT) && sclk_fall && !cs_high && (bit_idx == 3'h7)
            && (r_reg.cmd == flash_cmd_pkg::OP_READ) && (r_reg.addr == flash_cmd_pkg::ADDR_TOP)
            |=> r_reg.addr == 24'h000000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("address did not wrap");
    property p_ppb_sticky;
        r_reg.permanent_lock_bit |=> r_reg.permanent_lock_bit && $stable(r_reg.bp) && $stable(r_reg.otp_lock);
    endproperty
    a_ppb_sticky: assert property (p_ppb_sticky) else $error("frozen bits changed");
    property p_otp_refuse;
        r_reg.permanent_lock_bit && !r_reg.otp_lock |=> !r_reg.otp_lock;
    endproperty
    a_otp_refuse: assert property (p_otp_refuse) else $error("sector lock set after freeze");
    property p_reserved;
        cfg_byte[7:6] == 2'h0 && cfg_byte[1:0] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved config bits set");
    property p_quad_clocks;
        quad_dummy_clocks_o == (r_reg.cfg[5] ? (r_reg.cfg[4] ? 4'hA : 4'h8)
            : (r_reg.cfg[4] ? 4'h4 : 4'h6));
    endproperty
    a_quad_clocks: assert property (p_quad_clocks) else $error("dummy clock mismatch");
    c_wsr: cover property (wsr_valid);
    c_wrap: cover property ((r_reg.addr == flash_cmd_pkg::ADDR_TOP) ##[1:300] (r_reg.addr == 24'h0));
    c_cfg_read: cover property ((r_reg.state == flash_cmd_pkg::ST_OUT)
        && (r_reg.cmd == flash_cmd_pkg::OP_READ_CONFIG) && sclk_fall);
    c_busy_read: cover property ((r_reg.state == flash_cmd_pkg::ST_HOLD)
        && (r_reg.cmd == flash_cmd_pkg::OP_READ));
endmodule : flash_cmd

/* flash_cmd_tb.sv */
// bench for flash_cmd: host model on the pins, byte scoreboard, status checks
// assumes: flash_cmd_pkg and spi_host compiled first
`timescale 1ns/100ps

module flash_cmd_tb;
    localparam int TW = 2000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, sclk, mosi, miso, oe, busy, write_enable_latch, perm;
    logic [23:0] addr;
    logic otp = 1'b0;
    logic twe = 1'b0;
    logic vol = 1'b0;
    logic xbusy = 1'b0;
    logic [7:0] twd = 8'h00;
    logic [7:0] cfg, rxb;
    logic [3:0] prot, qck;
    logic [1:0] drv;
    logic [2:0] dby;
    logic [15:0] rxn;
    logic [7:0] exp_q[$];
    logic [2:0] dtab [4] = '{3'h3, 3'h2, 3'h4, 3'h5};
    logic quiet = 1'b0;
    logic oe_seen = 1'b0;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int t_cs = 0;
    // undriven line shows the inverse, so a missing drive never reads as data
    wire miso_w = oe ? miso : ~miso;

    function automatic logic [7:0] mval(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'h5A;
    endfunction : mval

    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    always @(posedge clk_i) if (oe === 1'b1) oe_seen <= 1'b1;
    always @(posedge cs_n) t_cs = cyc;

    flash_cmd #(.TW_CYCLES(TW)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi),
        .miso_o(miso), .miso_oe_o(oe), .mem_addr_o(addr), .mem_data_i(mval(addr)),
        .ext_busy_i(xbusy), .otp_mode_i(otp), .volatile_sr_i(vol), .tuning_we_i(twe),
        .tuning_wdata_i(twd), .cycle_busy_flag_o(busy), .write_enable_latch_o(write_enable_latch),
        .permanent_lock_bit_o(perm), .protect_field_o(prot), .drive_strength_o(drv),
        .dummy_bytes_o(dby), .quad_dummy_clocks_o(qck));
    spi_host host_u (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso_w),
        .rx_byte_o(rxb), .rx_cnt_o(rxn));

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] ex);
        n_compared++;
        if (seen !== ex) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic stat(input logic [7:0] v);
        exp_q.push_back(v);
        host_u.frame('{8'h05}, 0, 8);
    endtask : stat

    // mid: exercise reads while the timed cycle runs
    task automatic write_status_cmd(input logic [7:0] v, input logic mid);
        int t0;
        host_u.frame('{8'h06}, 0, 0);
        chk("latch", write_enable_latch, 24'h1);
        host_u.frame('{8'h01, v}, 0, 0);
        t0 = t_cs;
        chk("busy", busy, 24'h1);
        if (mid) begin
            repeat (2) exp_q.push_back(cfg);
            host_u.frame('{8'h95}, 0, 16);
            stat(8'h03);
            quiet = 1'b1;
            oe_seen = 1'b0;
            host_u.frame('{8'h03, 8'h00, 8'h00, 8'h10}, 0, 16);
            chk("ignored read", oe_seen, 24'h0);
            quiet = 1'b0;
        end
        while (busy !== 1'b0 && cyc - t0 < TW + 50) @(negedge clk_i);
        chk("tw", cyc - t0 inside {[TW + 1 : TW + 10]}, 24'h1);
        chk("latch", write_enable_latch, 24'h0);
    endtask : write_status_cmd

    always @(rxn) begin
        if (!quiet && rxn != 16'h0000) begin
            chk("pending", exp_q.size() > 0, 24'h1);
            if (exp_q.size() > 0) chk("rx byte", rxb, exp_q.pop_front());
        end
    end

    initial begin
        #(60000 * 8);
        num_errors++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h6c8282fd));
        repeat (8) @(posedge clk_i);
        @(negedge clk_i) rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        chk("busy", busy, 24'h0);
        chk("perm", perm, 24'h0);
        chk("cfg", {drv, dby, qck}, {2'h0, 3'h3, 4'h6});
        $display("reset test done");
        for (int c = 0; c < 4; c++) begin
            cfg = 8'($urandom);
            cfg[5:4] = c[1:0];
            @(negedge clk_i);
            twe = 1'b1;
            twd = cfg;
            @(negedge clk_i) twe = 1'b0;
            cfg = cfg & 8'h3C;
            repeat (3) exp_q.push_back(cfg);
            host_u.frame('{8'h95}, 0, 24);
            chk("drive", drv, cfg[3:2]);
            chk("dummy", dby, dtab[c]);
            chk("quad", qck, {dtab[c], 1'b0});
        end
        $display("config test done");
        @(negedge clk_i) xbusy = 1'b1;
        stat(8'h01);
        host_u.frame('{8'h06}, 0, 0);
        chk("busy latch", write_enable_latch, 24'h0);
        @(negedge clk_i) xbusy = 1'b0;
        host_u.frame('{8'h01, 8'h3C}, 0, 0);
        chk("busy", busy, 24'h0);
        host_u.frame('{8'h06}, 0, 0);
        host_u.frame('{8'h01, 8'h3C}, 1, 0);
        chk("busy", busy, 24'h0);
        $display("refusal test done");
        write_status_cmd(8'h3F, 1'b1);
        chk("protect", prot, 24'hF);
        stat(8'h3C);
        $display("status write test done");
        for (int i = 0; i < 4; i++) exp_q.push_back(mval(24'(24'hFFFFFE + i)));
        host_u.frame('{8'h03, 8'hFF, 8'hFF, 8'hFE}, 0, 36);
        chk("drive off", oe, 24'h0);
        $display("read test done");
        write_status_cmd(8'h00, 1'b0);
        @(negedge clk_i) otp = 1'b1;
        write_status_cmd(8'h18, 1'b0);
        write_status_cmd(8'h00, 1'b0);
        stat(8'h18);
        @(negedge clk_i) otp = 1'b0;
        write_status_cmd(8'h80, 1'b0);
        write_status_cmd(8'h3C, 1'b0);
        chk("perm lock", {perm, prot}, 24'h10);
        @(negedge clk_i) otp = 1'b1;
        write_status_cmd(8'h80, 1'b0);
        stat(8'h18);
        @(negedge clk_i) vol = 1'b1;
        write_status_cmd(8'h08, 1'b0);
        stat(8'h08);
        $display("lock test done");
        chk("leftover", exp_q.size(), 24'h0);
        tally_and_finish();
    end
endmodule : flash_cmd_tb

/* flash_sync.sv */
// package of shared constants for the serial flash command block, and the pin synchroniser
// assumes: a single 125 MHz clock; pins arrive asynchronously to it
package flash_cmd_pkg;
    // opcodes
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_READ_CONFIG = 8'h95;
    // status register field positions
    localparam int SR_BUSY = 0;
    localparam int SR_WEL = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 5;
    localparam int SR_TB = 3;
    localparam int SR_SECT = 4;
    localparam int SR_EBL = 6;
    localparam int SR_TOP = 7;
    // read_tuning_config field positions, mask and reset value
    localparam int CFG_DRV_LO = 2;
    localparam int CFG_DRV_HI = 3;
    localparam int CFG_DUMMY_LO = 4;
    localparam int CFG_DUMMY_HI = 5;
    localparam logic [7:0] CFG_MASK = 8'h3C;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // frame counters
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [4:0] DATA_BITS = 5'h08;
    localparam logic [4:0] DATA_OVER = 5'h09;
    localparam logic [23:0] ADDR_TOP = 24'hFFFFFF;
    // self-timed status write time
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned TW_US = 5000;
    localparam int unsigned TW_CYCLES_DEF = TW_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD = 3'h1,
        ST_ADDR = 3'h2,
        ST_WDATA = 3'h3,
        ST_OUT = 3'h4,
        ST_HOLD = 3'h5
    } state_e;

    // dummy byte count selected by the two-bit code
    function automatic logic [2:0] dummy_bytes(input logic [1:0] code);
        unique case (code)
            2'h0: dummy_bytes = 3'h3;
            2'h1: dummy_bytes = 3'h2;
            2'h2: dummy_bytes = 3'h4;
            2'h3: dummy_bytes = 3'h5;
        endcase
    endfunction : dummy_bytes
endpackage : flash_cmd_pkg

`timescale 1ns/100ps

module sync_edge #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous pins
    input wire logic [WIDTH-1:0] async_i,
    // synchronised level and edges
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] rise_o,
    output logic [WIDTH-1:0] fall_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_s;

    sync_s r_reg;
    sync_s r_next;

    // meta is read only by sync, never by the edge logic
    always_comb begin
        r_next = r_reg;
        r_next.meta = async_i;
        r_next.sync = r_reg.meta;
        r_next.prev = r_reg.sync;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // start at the idle levels so no false edge follows reset
            r_reg <= {3{RST_VAL}};
        end else begin
            r_reg <= r_next;
        end
    end

    assign level_o = r_reg.sync;
    assign rise_o = r_reg.sync & ~r_reg.prev;
    assign fall_o = ~r_reg.sync & r_reg.prev;
endmodule : sync_edge

/* spi_host.sv */
// host side spi master model, mode 0, for the serial flash command block
// assumes: one bench process calls frame(); link clock stands still between frames
`timescale 1ns/100ps

module spi_host #(
    parameter real HALF_NS = 62.5
) (
    // spi pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    // captured bytes
    output logic [7:0] rx_byte_o,
    output logic [15:0] rx_cnt_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        rx_byte_o = 8'h00;
        rx_cnt_o = 16'h0000;
    end

    // trim drops trailing bits on purpose to break the framing
    task automatic frame(input logic [7:0] tx[$], input int trim, input int rx_bits);
        int ntx;
        logic [7:0] sh;
        ntx = 8 * tx.size() - trim;
        sh = 8'h00;
        cs_n_o = 1'b0;
        #(HALF_NS);
        for (int i = 0; i < ntx + rx_bits; i++) begin
            if (i < ntx) begin
                mosi_o = tx[i / 8][7 - i % 8];
            end else begin
                mosi_o = ~mosi_o;
            end
            #(HALF_NS);
            sclk_o = 1'b1;
            if (i >= ntx) begin
                sh = {sh[6:0], miso_i};
                if ((i - ntx) % 8 == 7) begin
                    rx_byte_o = sh;
                    rx_cnt_o = rx_cnt_o + 16'h0001;
                end
            end
            #(HALF_NS);
            sclk_o = 1'b0;
        end
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #(2 * HALF_NS);
    endtask : frame
endmodule : spi_host
